// ==== slsp_pkg.sv ====
package slsp_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int LANES      = 1;             // Lanes in the channel
   localparam int LANE_BITS  = 64;            // Data bits per lane
   localparam int LANE_BYTES = 8;             // Keep bits per lane
   localparam int DATA_W     = LANE_BITS * LANES;
   localparam int KEEP_W     = LANE_BYTES * LANES;
   localparam int CNT_W      = $clog2(KEEP_W + 1);
   localparam int FIFO_DEPTH = 16;            // Transmit buffer words
   localparam int BEAT_W     = DATA_W + KEEP_W + 1;

   // ----------------------------------------------------------------
   // Reset and full-count values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RST = '0;
   localparam logic [KEEP_W-1:0] KEEP_ALL = '1;
   localparam logic [CNT_W-1:0]  CNT_RST  = '0;
   localparam logic [CNT_W-1:0]  CNT_FULL = CNT_W'(KEEP_W);

   // ----------------------------------------------------------------
   // Link block kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SLSP_BLK_IDLE = 2'b00,
      SLSP_BLK_DATA = 2'b01,
      SLSP_BLK_SEP  = 2'b10
   } slsp_blk_type;

   // Number of set keep bits
   function automatic logic [CNT_W-1:0] slsp_ones(input logic [KEEP_W-1:0] keep);
      logic [CNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < KEEP_W; i++) begin
         n = n + CNT_W'(keep[i]);
      end
      return n;
   endfunction

   // Contiguous low-justified keep mask of a byte count
   function automatic logic [KEEP_W-1:0] slsp_mask(input logic [CNT_W-1:0] cnt);
      logic [KEEP_W-1:0] m;
      m = '0;
      for (int i = 0; i < KEEP_W; i++) begin
         m[i] = (CNT_W'(i) < cnt);
      end
      return m;
   endfunction

endpackage

// ==== slsp_if.sv ====
`timescale 1ns/10ps
interface slsp_if;
   import slsp_pkg::*;

   // ----------------------------------------------------------------
   // Transmit and receive user streams
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] tx_data;
   logic [KEEP_W-1:0] tx_keep;
   logic              tx_last;
   logic              tx_valid;
   logic              tx_ready;
   logic [DATA_W-1:0] rx_data;
   logic [KEEP_W-1:0] rx_keep;
   logic              rx_last;
   logic              rx_valid;

   modport dev (input tx_data, tx_keep, tx_last, tx_valid, output tx_ready,
                output rx_data, rx_keep, rx_last, rx_valid);
   modport usr (output tx_data, tx_keep, tx_last, tx_valid, input tx_ready,
                input rx_data, rx_keep, rx_last, rx_valid);
endinterface

// ==== slsp_dev.sv ====
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Transmit buffer
// ------------------------------------------------------------------
module slsp_fifo
   import slsp_pkg::*;
#(
   parameter int WIDTH = BEAT_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_ce,
   input  wire logic             i_valid,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_ready,
   output logic                  o_valid,
   output logic [WIDTH-1:0]      o_data,
   input  wire logic             i_ready
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_reg, wr_next;
   logic [PW-1:0]    rd_reg, rd_next;
   logic [PW:0]      cnt_reg, cnt_next;
   logic             push;
   logic             pop;

   // Honest full and empty flags
   assign o_ready = (cnt_reg != (PW+1)'(DEPTH));
   assign o_valid = (cnt_reg != '0);
   assign o_data  = mem[rd_reg];
   assign push    = i_ce && i_valid && o_ready;
   assign pop     = i_ce && i_ready && o_valid;

   // Pointer and count update
   always_comb begin
      wr_next  = push ? wr_reg + PW'(1) : wr_reg;
      rd_next  = pop ? rd_reg + PW'(1) : rd_reg;
      cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
   end

   // Storage, no reset needed
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_reg] <= i_data;
      end
   end

   // Pointer registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule

// ------------------------------------------------------------------
// Device end of the user stream port
// ------------------------------------------------------------------
module slsp_dev
   import slsp_pkg::*;
#(
   parameter bit FRAMED = 1'b1
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_ce,
   slsp_if.dev                    bus,
   input  wire logic              i_ltx_ready,
   output slsp_blk_type           o_ltx_kind,
   output logic [DATA_W-1:0]      o_ltx_data,
   output logic [CNT_W-1:0]       o_ltx_count,
   output logic                   o_ltx_in_frame,
   input  wire slsp_blk_type      i_lrx_kind,
   input  wire logic [DATA_W-1:0] i_lrx_data,
   input  wire logic [CNT_W-1:0]  i_lrx_count
);
   typedef enum logic {
      SLSP_TX_GAP   = 1'b0,
      SLSP_TX_FRAME = 1'b1
   } slsp_txs_type;

   logic [BEAT_W-1:0] beat_in;
   logic [BEAT_W-1:0] beat_out;
   logic              buf_valid;
   logic              beat_last;
   logic [KEEP_W-1:0] beat_keep;
   logic [DATA_W-1:0] beat_data;
   logic              drain;

   slsp_txs_type      st_reg, st_next;
   slsp_blk_type      kind_reg, kind_next;
   logic [DATA_W-1:0] ltx_data_reg, ltx_data_next;
   logic [CNT_W-1:0]  ltx_cnt_reg, ltx_cnt_next;

   logic [DATA_W-1:0] rx_data_reg, rx_data_next;
   logic [KEEP_W-1:0] rx_keep_reg, rx_keep_next;
   logic              rx_last_reg, rx_last_next;
   logic              rx_valid_reg, rx_valid_next;

   // ----------------------------------------------------------------
   // Transmit side
   // ----------------------------------------------------------------

   // Streaming variant drops last and keep
   assign beat_in = {FRAMED && bus.tx_last, bus.tx_keep, bus.tx_data};

   // Ready is buffer space; push only on ready and valid
   slsp_fifo #(
      .WIDTH (BEAT_W),
      .DEPTH (FIFO_DEPTH)
   ) i_slsp_fifo (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_valid (bus.tx_valid),
      .i_data  (beat_in),
      .o_ready (bus.tx_ready),
      .o_valid (buf_valid),
      .o_data  (beat_out),
      .i_ready (drain)
   );

   assign {beat_last, beat_keep, beat_data} = beat_out;
   assign drain = i_ltx_ready;

   // Block selection toward the link
   always_comb begin
      st_next       = st_reg;
      kind_next     = kind_reg;
      ltx_data_next = ltx_data_reg;
      ltx_cnt_next  = ltx_cnt_reg;
      if (i_ce && i_ltx_ready) begin
         if (buf_valid) begin
            ltx_data_next = beat_data;
            if (beat_last) begin
               kind_next    = SLSP_BLK_SEP;
               ltx_cnt_next = slsp_ones(beat_keep);
               st_next      = SLSP_TX_GAP;
            end else begin
               kind_next    = SLSP_BLK_DATA;
               ltx_cnt_next = CNT_FULL;
               st_next      = SLSP_TX_FRAME;
            end
         end else begin
            kind_next    = SLSP_BLK_IDLE;
            ltx_cnt_next = CNT_RST;
         end
      end
   end

   // Transmit registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_reg       <= SLSP_TX_GAP;
         kind_reg     <= SLSP_BLK_IDLE;
         ltx_data_reg <= DATA_RST;
         ltx_cnt_reg  <= CNT_RST;
      end else begin
         st_reg       <= st_next;
         kind_reg     <= kind_next;
         ltx_data_reg <= ltx_data_next;
         ltx_cnt_reg  <= ltx_cnt_next;
      end
   end

   assign o_ltx_kind     = kind_reg;
   assign o_ltx_data     = ltx_data_reg;
   assign o_ltx_count    = ltx_cnt_reg;
   assign o_ltx_in_frame = FRAMED && (st_reg == SLSP_TX_FRAME);

   // ----------------------------------------------------------------
   // Receive side
   // ----------------------------------------------------------------

   // Present link blocks to the application
   always_comb begin
      rx_data_next  = rx_data_reg;
      rx_keep_next  = rx_keep_reg;
      rx_last_next  = rx_last_reg;
      rx_valid_next = rx_valid_reg;
      if (i_ce) begin
         rx_valid_next = 1'b0;
         rx_last_next  = 1'b0;
         rx_keep_next  = KEEP_ALL;
         unique case (i_lrx_kind)
            SLSP_BLK_DATA: begin
               rx_valid_next = 1'b1;
               rx_data_next  = i_lrx_data;
            end
            SLSP_BLK_SEP: begin
               rx_valid_next = (i_lrx_count != CNT_RST);
               rx_data_next  = i_lrx_data;
               rx_last_next  = FRAMED && (i_lrx_count != CNT_RST);
               rx_keep_next  = FRAMED ? slsp_mask(i_lrx_count) : KEEP_ALL;
            end
            default: begin
               rx_valid_next = 1'b0;
            end
         endcase
      end
   end

   // Receive registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_data_reg  <= DATA_RST;
         rx_keep_reg  <= KEEP_ALL;
         rx_last_reg  <= 1'b0;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_data_reg  <= rx_data_next;
         rx_keep_reg  <= rx_keep_next;
         rx_last_reg  <= rx_last_next;
         rx_valid_reg <= rx_valid_next;
      end
   end

   assign bus.rx_data  = rx_data_reg;
   assign bus.rx_keep  = rx_keep_reg;
   assign bus.rx_last  = rx_last_reg;
   assign bus.rx_valid = rx_valid_reg;
endmodule

// ==== slsp_usr.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Application end of the user stream port
// ------------------------------------------------------------------
module slsp_usr
   import slsp_pkg::*;
#(
   parameter bit FRAMED = 1'b1
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_ce,
   slsp_if.usr                    bus,
   input  wire logic              i_src_valid,
   input  wire logic [DATA_W-1:0] i_src_data,
   input  wire logic [KEEP_W-1:0] i_src_keep,
   input  wire logic              i_src_last,
   output logic                   o_src_ready,
   output logic                   o_snk_valid,
   output logic [DATA_W-1:0]      o_snk_data,
   output logic [KEEP_W-1:0]      o_snk_keep,
   output logic                   o_snk_last
);
   logic              hv_reg, hv_next;
   logic [DATA_W-1:0] hd_reg, hd_next;
   logic [KEEP_W-1:0] hk_reg, hk_next;
   logic              hl_reg, hl_next;
   logic              taken;

   logic              sv_reg, sv_next;
   logic [DATA_W-1:0] sd_reg, sd_next;
   logic [KEEP_W-1:0] sk_reg, sk_next;
   logic              sl_reg, sl_next;

   // ----------------------------------------------------------------
   // Transmit holding stage
   // ----------------------------------------------------------------
   assign taken       = hv_reg && bus.tx_ready;
   assign o_src_ready = !hv_reg || bus.tx_ready;

   // Hold beat until the device takes it
   always_comb begin
      hv_next = hv_reg;
      hd_next = hd_reg;
      hk_next = hk_reg;
      hl_next = hl_reg;
      if (i_ce) begin
         if (i_src_valid && o_src_ready) begin
            hv_next = 1'b1;
            hd_next = i_src_data;
            hl_next = FRAMED && i_src_last;
            hk_next = slsp_mask(slsp_ones(i_src_keep));
         end else if (taken) begin
            hv_next = 1'b0;
         end
      end
   end

   // Holding registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hv_reg <= 1'b0;
         hd_reg <= DATA_RST;
         hk_reg <= KEEP_ALL;
         hl_reg <= 1'b0;
      end else begin
         hv_reg <= hv_next;
         hd_reg <= hd_next;
         hk_reg <= hk_next;
         hl_reg <= hl_next;
      end
   end

   assign bus.tx_valid = hv_reg;
   assign bus.tx_data  = hd_reg;
   assign bus.tx_keep  = hk_reg;
   assign bus.tx_last  = hl_reg;

   // ----------------------------------------------------------------
   // Receive sink, no back-pressure
   // ----------------------------------------------------------------
   always_comb begin
      sv_next = sv_reg;
      sd_next = sd_reg;
      sk_next = sk_reg;
      sl_next = sl_reg;
      if (i_ce) begin
         sv_next = bus.rx_valid;
         if (bus.rx_valid) begin
            sd_next = bus.rx_data;
            sk_next = bus.rx_keep;
            sl_next = bus.rx_last;
         end
      end
   end

   // Sink registers
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sv_reg <= 1'b0;
         sd_reg <= DATA_RST;
         sk_reg <= KEEP_ALL;
         sl_reg <= 1'b0;
      end else begin
         sv_reg <= sv_next;
         sd_reg <= sd_next;
         sk_reg <= sk_next;
         sl_reg <= sl_next;
      end
   end

   assign o_snk_valid = sv_reg;
   assign o_snk_data  = sd_reg;
   assign o_snk_keep  = sk_reg;
   assign o_snk_last  = sl_reg;
endmodule

// ==== slsp_properties.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Interface checker
// ----------------------------------------------------------------
module slsp_properties
   import slsp_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst_b,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic [KEEP_W-1:0] tx_keep,
   input wire logic              tx_last,
   input wire logic              tx_valid,
   input wire logic              tx_ready,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic [KEEP_W-1:0] rx_keep,
   input wire logic              rx_last,
   input wire logic              rx_valid
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   // Receive side
   AST_RX_KEEP_ALL: assert property (rx_valid && !rx_last |-> rx_keep == KEEP_ALL)
      else $error("receive keep not full on inner beat");
   AST_RX_KEEP_PACKED: assert property (rx_valid && rx_last |->
      rx_keep != '0 && (KEEP_W'(rx_keep + 1'b1) & rx_keep) == '0)
      else $error("receive keep not a packed mask on last beat");
   AST_RX_LAST_VALID: assert property (rx_last |-> rx_valid)
      else $error("receive last without valid");
   AST_RX_DATA_HOLD: assert property (!rx_valid |-> $stable(rx_data))
      else $error("receive data moved without valid");

   // Transmit side and reset exit
   AST_TX_DATA_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("transmit beat dropped while refused");
   AST_TX_CTRL_HOLD: assert property (tx_valid && !tx_ready |=> $stable(tx_keep) && $stable(tx_last))
      else $error("transmit control moved while refused");
   AST_TX_LAST_KEEP: assert property (tx_valid && tx_last |->
      tx_keep != '0 && (KEEP_W'(tx_keep + 1'b1) & tx_keep) == '0)
      else $error("transmit keep not packed from low byte");
   AST_TX_READY_FALL: assert property ($fell(tx_ready) |-> $past(tx_valid))
      else $error("ready fell without a pushed beat");
   AST_RESET_EXIT: assert property ($rose(i_rst_b) |-> tx_ready && !rx_valid && !tx_valid)
      else $error("wrong state at reset exit");

   // Main scenarios
   COV_FULL: cover property (tx_valid && !tx_ready);
   COV_LAST: cover property (rx_valid && rx_last);
   COV_B2B:  cover property (rx_valid ##1 rx_valid);
endmodule

// ==== slsp_tb.sv ====
`timescale 1ns/10ps
module slsp_tb;
   import slsp_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic              i_clk, i_rst_b, i_ce, i_ltx_ready;
   logic              src_valid, src_last, src_ready, src_taken, fresh, snk_fresh, stall, rnd;
   logic [DATA_W-1:0] src_data, snk_data, ltx_data;
   logic [KEEP_W-1:0] src_keep, snk_keep;
   logic              snk_valid, snk_last, ltx_in_frame;
   logic [CNT_W-1:0]  ltx_count;
   slsp_blk_type      ltx_kind, lrx_kind;
   logic [31:0]       seed, ce_seed;
   logic [79:0]       exp_q[$];
   int                failures, check_count, cycles, taken, pause_seen;
   slsp_if            bus();
   slsp_if            bus_s();
   slsp_blk_type      s_kind;
   logic              s_in_frame;

   slsp_usr i_slsp_usr (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .bus(bus),
      .i_src_valid(src_valid), .i_src_data(src_data), .i_src_keep(src_keep), .i_src_last(src_last),
      .o_src_ready(src_ready), .o_snk_valid(snk_valid), .o_snk_data(snk_data),
      .o_snk_keep(snk_keep), .o_snk_last(snk_last));
   slsp_dev i_slsp_dev (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .bus(bus),
      .i_ltx_ready(i_ltx_ready), .o_ltx_kind(ltx_kind), .o_ltx_data(ltx_data),
      .o_ltx_count(ltx_count), .o_ltx_in_frame(ltx_in_frame),
      .i_lrx_kind(lrx_kind), .i_lrx_data(ltx_data), .i_lrx_count(ltx_count));
   // Streaming variant shadowing the same pushes, drain and link blocks
   slsp_dev #(.FRAMED(1'b0)) i_slsp_dev_strm (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .bus(bus_s),
      .i_ltx_ready(i_ltx_ready), .o_ltx_kind(s_kind), .o_ltx_data(), .o_ltx_count(),
      .o_ltx_in_frame(s_in_frame), .i_lrx_kind(lrx_kind), .i_lrx_data(ltx_data), .i_lrx_count(ltx_count));
   slsp_properties i_slsp_properties (.i_clk(i_clk), .i_rst_b(i_rst_b), .tx_data(bus.tx_data),
      .tx_keep(bus.tx_keep), .tx_last(bus.tx_last), .tx_valid(bus.tx_valid), .tx_ready(bus.tx_ready),
      .rx_data(bus.rx_data), .rx_keep(bus.rx_keep), .rx_last(bus.rx_last), .rx_valid(bus.rx_valid));

   // Loopback: only a freshly launched block reaches the receiver
   assign lrx_kind = fresh ? ltx_kind : SLSP_BLK_IDLE;

   // Shadow buffer sees exactly the framed buffer's pushes
   assign bus_s.tx_data  = bus.tx_data;
   assign bus_s.tx_keep  = bus.tx_keep;
   assign bus_s.tx_last  = bus.tx_last;
   assign bus_s.tx_valid = bus.tx_valid && bus.tx_ready;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Packed low mask of the set keep bits
   function automatic logic [KEEP_W-1:0] packed_keep(input logic [KEEP_W-1:0] k);
      int n;
      n = 0;
      for (int i = 0; i < KEEP_W; i++) n += k[i];
      return {KEEP_W{1'b1}} >> (KEEP_W - n);
   endfunction

   task automatic check(input logic [79:0] got, input logic [79:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Presents one beat, holds it until taken, then optional idle gap
   task automatic put_beat(input logic l, input logic [KEEP_W-1:0] k, input int gap);
      seed = lfsr_next(seed);
      src_data = {seed, lfsr_next(seed)};
      src_keep = (l && k == '0) ? 8'h80 : k;
      src_last = l;
      src_valid = 1'b1;
      do @(negedge i_clk); while (!src_taken);
      if (gap > 0) begin
         src_valid = 1'b0;
         repeat (gap) @(negedge i_clk);
      end
   endtask

   // ----------------------------------------------------------------
   // Clock, link model and monitors
   // ----------------------------------------------------------------
   always #25 i_clk = ~i_clk;

   always @(negedge i_clk) begin
      ce_seed = lfsr_next(ce_seed);
      i_ce <= rnd ? (ce_seed[7:4] != 4'h0) : 1'b1;
      i_ltx_ready <= stall ? 1'b0 : (rnd ? (ce_seed[3] | ce_seed[5]) : 1'b1);
   end

   // Watchdog on the whole run
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         stop_test();
      end
   end

   // Source acceptance and link freshness
   always @(posedge i_clk) begin
      src_taken <= i_ce && src_valid && src_ready;
      if (i_ce && src_valid && src_ready) begin
         taken++;
         exp_q.push_back({src_data, src_last ? packed_keep(src_keep) : KEEP_ALL, src_last});
      end
      if (i_ce)
         fresh <= i_ltx_ready;
      snk_fresh <= i_ce;
   end

   // Every sink beat is accepted and compared in order
   always @(negedge i_clk) begin
      if (i_rst_b && snk_fresh && snk_valid === 1'b1) begin
         if (exp_q.size() == 0)
            check({snk_data, snk_keep, snk_last}, 80'h0);
         else
            check({snk_data, snk_keep, snk_last}, exp_q.pop_front());
      end
      if (i_rst_b && fresh) begin
         if (ltx_kind == SLSP_BLK_DATA)
            check(80'(ltx_count), 80'(CNT_FULL));
         if (ltx_kind == SLSP_BLK_IDLE)
            check(80'(ltx_count), 80'h0);
         if (ltx_kind != SLSP_BLK_IDLE)
            check(80'(ltx_in_frame), 80'(ltx_kind == SLSP_BLK_DATA));
         if (ltx_kind == SLSP_BLK_IDLE && ltx_in_frame)
            pause_seen++;
         check(80'(s_kind == SLSP_BLK_SEP || s_in_frame), 80'h0);
      end
      if (i_rst_b && bus_s.rx_valid === 1'b1)
         check(80'({bus_s.rx_keep, bus_s.rx_last}), 80'({KEEP_ALL, 1'b0}));
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      i_rst_b = 1'b0;
      i_ce = 1'b1;
      i_ltx_ready = 1'b1;
      {src_valid, src_last, src_taken, fresh, snk_fresh, stall, rnd} = '0;
      src_data = '0;
      src_keep = '0;
      seed = 32'h33;
      ce_seed = 32'h33;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      check(80'(bus.tx_ready), 80'h1);
      check(80'(bus.rx_valid), 80'h0);
      check(80'(bus.rx_keep), 80'(KEEP_ALL));
      check(80'($bits(bus.tx_data)), 80'(64 * LANES));
      check(80'($bits(bus.rx_data)), 80'(64 * LANES));
      i_rst_b = 1'b1;
      // Fill the buffer with the link stalled, garbage keep on inner beats
      stall = 1'b1;
      src_data = 64'h0123_4567_89ab_cdef;
      src_keep = 8'h5a;
      src_valid = 1'b1;
      repeat (30) @(negedge i_clk);
      check(80'(taken), 80'(FIFO_DEPTH + 1));
      check(80'(bus.tx_ready), 80'h0);
      stall = 1'b0;
      do @(negedge i_clk); while (!src_taken);
      put_beat(1'b1, 8'h3c, 0);
      // Pause in mid-frame long enough to drain the backlog, then single-beat frames
      put_beat(1'b0, 8'h00, 25);
      put_beat(1'b1, 8'hff, 0);
      for (int n = 0; n < KEEP_W; n++) put_beat(1'b1, 8'h01 << n, 0);
      // Random traffic with stalls and clock-enable gaps
      rnd = 1'b1;
      repeat (300) put_beat(seed[2] & seed[9], seed[23:16], (seed[5:4] == 2'b00) ? int'(seed[7:6]) : 0);
      src_valid = 1'b0;
      rnd = 1'b0;
      for (int w = 0; w < 300 && exp_q.size() != 0; w++) @(negedge i_clk);
      check(80'(exp_q.size()), 80'h0);
      check(80'(pause_seen != 0), 80'h1);
      stop_test();
   end
endmodule
